// file: rtl/dac_front_pkg.sv
/*
  Shared constants and types for the video DAC digital front end:
  pixel widths, output level kinds, configuration decode, register map.
  Assumes a single clock domain and the plain register port of the top.
*/
`default_nettype none

package dac_front_pkg;

  // ==========================================================
  // Pixel path
  localparam int PIX_W      = 10;
  localparam int NUM_CH     = 3;
  localparam int LVL_W      = 2;
  localparam int CH_W       = PIX_W + LVL_W;
  localparam int WORD_W     = NUM_CH * CH_W;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W      = 3;

  localparam int CH_RED     = 0;
  localparam int CH_GREEN   = 1;
  localparam int CH_BLUE    = 2;

  // Digital codes shown beside the blank and sync level kinds
  localparam logic [PIX_W-1:0] CODE_ZERO     = 10'h000;
  localparam logic [PIX_W-1:0] CODE_MID      = 10'h200;
  localparam logic [PIX_W-1:0] CODE_SYNC_NEG = 10'h000;
  localparam logic [PIX_W-1:0] CODE_SYNC_POS = 10'h3ff;

  typedef enum logic [LVL_W-1:0] {
    LVL_DATA,
    LVL_BLANK,
    LVL_SYNC_NEG,
    LVL_SYNC_POS
  } level_t;

  typedef enum logic [1:0] {
    CFG_GBR_444,
    CFG_YPBPR_444,
    CFG_YPBPR_422,
    CFG_RESERVED
  } cfg_t;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

  localparam int CTRL_FORCE_BLANK = 0;

  localparam int ST_CFG_LSB      = 0;
  localparam int ST_COLOUR_BIT   = 2;
  localparam int ST_SYNC_ALL_BIT = 3;
  localparam int ST_COLOUR_KNOWN = 4;
  localparam int ST_SYNC_KNOWN   = 5;
  localparam int ST_DIRECT_PIN   = 6;
  localparam int ST_LEVEL_LSB    = 8;

  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Direct pin and latched colour bit select the configuration
  function automatic cfg_t cfg_decode(input logic direct, input logic colour);
    case ({direct, colour})
      2'h0:    cfg_decode = CFG_GBR_444;
      2'h1:    cfg_decode = CFG_YPBPR_444;
      2'h2:    cfg_decode = CFG_YPBPR_422;
      default: cfg_decode = CFG_RESERVED;
    endcase
  endfunction : cfg_decode

endpackage : dac_front_pkg

`default_nettype wire

// file: rtl/pix_fifo_if.sv
/*
  Carrier between the front end and its pixel FIFO.
  Assumes valid/ready handshakes on both sides, one clock.
*/
`default_nettype none

interface pix_fifo_if #(
  parameter int W  = 36,
  parameter int CW = 3
);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic [CW-1:0] count;

  modport store (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, count
  );

  modport user (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data, count
  );
endinterface : pix_fifo_if

`default_nettype wire

// file: rtl/pix_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and CW can hold DEPTH.
*/
`default_nettype none

module pix_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 4,
  parameter int CW    = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Queue ports
  pix_fifo_if.store q
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem      [DEPTH];
  logic [W-1:0]  next_mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr;
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count,  next_count;
  logic          do_push, do_pop;

  assign q.push_ready = (count != CW'(DEPTH));
  assign q.pop_valid  = (count != '0);
  assign q.pop_data   = mem[rd_ptr];
  assign q.count      = count;
  assign do_push      = q.push_valid && q.push_ready;
  assign do_pop       = q.pop_valid && q.pop_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (do_push) begin
      next_mem[wr_ptr] = q.push_data;
      next_wr_ptr      = wr_ptr + PW'(1);
    end
    if (do_pop) begin
      next_rd_ptr = rd_ptr + PW'(1);
    end
    if (do_push && !do_pop) begin
      next_count = count + CW'(1);
    end else if (do_pop && !do_push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clk_en) begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule : pix_fifo

`default_nettype wire

// file: rtl/video_dac_input_mode_latch.sv
/*
  Digital input front end of a triple 10-bit video DAC: samples pixel
  buses and blank/sync controls, overrides data with blank or sync
  levels, latches the second mode pin after sync transitions, and queues
  per-channel codes with level kinds toward the converters.
  Assumes every input is synchronous to clk and a plain register port.
*/
// The strobed register port and the register addresses were left to the implementer.
`default_nettype none

module video_dac_input_mode_latch
  import dac_front_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Pixel inputs
  input  wire logic              pixel_valid,
  input  wire logic [PIX_W-1:0]  red_pr_in,
  input  wire logic [PIX_W-1:0]  green_luma_in,
  input  wire logic [PIX_W-1:0]  blue_pb_in,
  output logic                   in_ready,
  // Blank and sync controls
  input  wire logic              blank_n,
  input  wire logic              sync_n,
  input  wire logic              sync_tri,
  // Mode pins
  input  wire logic              mode_sel_direct,
  input  wire logic              mode_sel_latched_pin,
  // Converter side
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [PIX_W-1:0]       red_pr_out,
  output logic [PIX_W-1:0]       green_luma_out,
  output logic [PIX_W-1:0]       blue_pb_out,
  output logic [LVL_W-1:0]       red_level,
  output logic [LVL_W-1:0]       green_level,
  output logic [LVL_W-1:0]       blue_level,
  // Latched mode state
  output logic                   colour_format_bit,
  output logic                   sync_on_all_bit,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata
);

  // ==========================================================
  // Per-channel level selection
  function automatic logic [CH_W-1:0] chan_word(
    input logic [PIX_W-1:0] data,
    input logic             blank_act,
    input logic             sync_act,
    input logic             tri_pos,
    input logic             sync_here,
    input logic [PIX_W-1:0] blank_code
  );
    level_t lvl;
    logic [PIX_W-1:0] code;
    lvl  = LVL_DATA;
    code = data;
    if (sync_act && sync_here) begin
      lvl  = tri_pos ? LVL_SYNC_POS : LVL_SYNC_NEG;
      code = tri_pos ? CODE_SYNC_POS : CODE_SYNC_NEG;
    end else if (sync_act || blank_act) begin
      lvl  = LVL_BLANK;
      code = blank_code;
    end
    chan_word = {lvl, code};
  endfunction : chan_word

  // ==========================================================
  // Capture stage
  logic [PIX_W-1:0] pix_q [NUM_CH];
  logic [PIX_W-1:0] next_pix_q [NUM_CH];
  logic             valid_q, next_valid_q;
  logic             blank_n_q, next_blank_n_q;
  logic             sync_n_q, next_sync_n_q;
  logic             sync_tri_q, next_sync_tri_q;
  logic             next_in_ready;
  logic             accept;

  assign accept = pixel_valid && in_ready;

  always_comb begin
    next_pix_q[CH_RED]   = red_pr_in;
    next_pix_q[CH_GREEN] = green_luma_in;
    next_pix_q[CH_BLUE]  = blue_pb_in;
    next_valid_q         = accept;
    next_blank_n_q       = blank_n;
    next_sync_n_q        = sync_n;
    next_sync_tri_q      = sync_tri;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        pix_q[i] <= CODE_ZERO;
      end
      valid_q    <= 1'b0;
      blank_n_q  <= 1'b1;
      sync_n_q   <= 1'b1;
      sync_tri_q <= 1'b0;
    end else if (clk_en) begin
      pix_q      <= next_pix_q;
      valid_q    <= next_valid_q;
      blank_n_q  <= next_blank_n_q;
      sync_n_q   <= next_sync_n_q;
      sync_tri_q <= next_sync_tri_q;
    end
  end

  // ==========================================================
  // Mode latch on sync transitions
  logic sync_prev, next_sync_prev;
  logic next_colour_format_bit, next_sync_on_all_bit;
  logic colour_known, next_colour_known;
  logic sync_known, next_sync_known;

  always_comb begin
    next_sync_prev         = sync_n_q;
    next_colour_format_bit = colour_format_bit;
    next_sync_on_all_bit   = sync_on_all_bit;
    next_colour_known      = colour_known;
    next_sync_known        = sync_known;
    // Sampled sync differs from its previous sample: this is the second edge
    if (sync_n_q != sync_prev) begin
      if (sync_n_q) begin
        next_colour_format_bit = mode_sel_latched_pin;
        next_colour_known      = 1'b1;
      end else begin
        next_sync_on_all_bit = mode_sel_latched_pin;
        next_sync_known      = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_prev         <= 1'b1;
      colour_format_bit <= 1'b0;
      sync_on_all_bit   <= 1'b0;
      colour_known      <= 1'b0;
      sync_known        <= 1'b0;
    end else if (clk_en) begin
      sync_prev         <= next_sync_prev;
      colour_format_bit <= next_colour_format_bit;
      sync_on_all_bit   <= next_sync_on_all_bit;
      colour_known      <= next_colour_known;
      sync_known        <= next_sync_known;
    end
  end

  // ==========================================================
  // Configuration and output word
  cfg_t             cfg;
  logic             force_blank;
  logic             blank_act, sync_act, ypbpr;
  logic [WORD_W-1:0] word;
  logic [PIX_W-1:0] blank_code [NUM_CH];
  logic             sync_here  [NUM_CH];

  assign cfg       = cfg_decode(mode_sel_direct, colour_format_bit);
  assign ypbpr     = (cfg != CFG_GBR_444);
  assign blank_act = !blank_n_q || force_blank;
  assign sync_act  = !sync_n_q;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      // Colour difference channels blank at mid code in YPbPr modes
      assign blank_code[ch] = (ypbpr && ch != CH_GREEN) ? CODE_MID : CODE_ZERO;
      assign sync_here[ch]  = (ch == CH_GREEN) || sync_on_all_bit;
      assign word[ch*CH_W +: CH_W] = chan_word(pix_q[ch], blank_act,
                                               sync_act, sync_tri_q,
                                               sync_here[ch],
                                               blank_code[ch]);
    end
  endgenerate

  // ==========================================================
  // Queue toward the converters
  pix_fifo_if #(.W(WORD_W), .CW(CNT_W)) fq ();

  pix_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .CW    (CNT_W)
  ) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .q       (fq.store)
  );

  logic take;
  logic [CNT_W:0] room_sum;

  assign fq.push_valid = valid_q;
  assign fq.push_data  = word;
  assign take          = !out_valid || out_ready;
  assign fq.pop_ready  = take;

  // Ignores pops: ready only if a further word is sure to fit
  always_comb begin
    room_sum = {1'b0, fq.count} + (CNT_W+1)'(valid_q) + (CNT_W+1)'(accept)
             + (CNT_W+1)'(1);
    next_in_ready = (room_sum <= (CNT_W+1)'(FIFO_DEPTH));
  end

  logic [WORD_W-1:0] out_word, next_out_word;
  logic              next_out_valid;

  always_comb begin
    next_out_word  = out_word;
    next_out_valid = out_valid;
    if (take) begin
      next_out_valid = fq.pop_valid;
      if (fq.pop_valid) begin
        next_out_word = fq.pop_data;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_word  <= '0;
      out_valid <= 1'b0;
      in_ready  <= 1'b0;
    end else if (clk_en) begin
      out_word  <= next_out_word;
      out_valid <= next_out_valid;
      in_ready  <= next_in_ready;
    end
  end

  assign red_pr_out     = out_word[CH_RED*CH_W +: PIX_W];
  assign green_luma_out = out_word[CH_GREEN*CH_W +: PIX_W];
  assign blue_pb_out    = out_word[CH_BLUE*CH_W +: PIX_W];
  assign red_level      = out_word[CH_RED*CH_W + PIX_W +: LVL_W];
  assign green_level    = out_word[CH_GREEN*CH_W + PIX_W +: LVL_W];
  assign blue_level     = out_word[CH_BLUE*CH_W + PIX_W +: LVL_W];

  // ==========================================================
  // Register port
  logic [DATA_W-1:0] next_reg_rdata;
  logic              next_force_blank;
  logic [DATA_W-1:0] status;

  always_comb begin
    status = RDATA_ZERO;
    status[ST_CFG_LSB +: 2]     = cfg;
    status[ST_COLOUR_BIT]       = colour_format_bit;
    status[ST_SYNC_ALL_BIT]     = sync_on_all_bit;
    status[ST_COLOUR_KNOWN]     = colour_known;
    status[ST_SYNC_KNOWN]       = sync_known;
    status[ST_DIRECT_PIN]       = mode_sel_direct;
    status[ST_LEVEL_LSB +: CNT_W] = fq.count;
  end

  always_comb begin
    next_force_blank = force_blank;
    next_reg_rdata   = RDATA_ZERO;
    if (reg_wr && reg_addr == REG_CTRL) begin
      next_force_blank = reg_wdata[CTRL_FORCE_BLANK];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: begin
          next_reg_rdata[CTRL_FORCE_BLANK] = force_blank;
        end
        REG_STATUS: begin
          next_reg_rdata = status;
        end
        default: begin
          next_reg_rdata = RDATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      force_blank <= 1'b0;
      reg_rdata   <= RDATA_ZERO;
    end else if (clk_en) begin
      force_blank <= next_force_blank;
      reg_rdata   <= next_reg_rdata;
    end
  end

endmodule : video_dac_input_mode_latch

`default_nettype wire

// file: verification/video_dac_chk.sv
/*
  Port checker for the video DAC front end.
  Assumes the single clk domain and the async sys_rst of the top.
*/
`default_nettype none

module video_dac_chk
  import dac_front_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             sys_rst,
  // Watched ports
  input wire logic             sync_n,
  input wire logic             mode_sel_latched_pin,
  input wire logic             out_valid,
  input wire logic             out_ready,
  input wire logic [PIX_W-1:0] red_pr_out,
  input wire logic [PIX_W-1:0] green_luma_out,
  input wire logic [PIX_W-1:0] blue_pb_out,
  input wire logic [LVL_W-1:0] red_level,
  input wire logic [LVL_W-1:0] green_level,
  input wire logic [LVL_W-1:0] blue_level,
  input wire logic             colour_format_bit,
  input wire logic             sync_on_all_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Converter word
  a_word_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable({red_pr_out, green_luma_out, blue_pb_out}))
    else $error("word changed while stalled");
  a_blank_all: assert property (
    out_valid && green_level == LVL_BLANK |->
      red_level == LVL_BLANK && blue_level == LVL_BLANK && green_luma_out == CODE_ZERO)
    else $error("blank not on all channels");
  a_data_all: assert property (
    out_valid && green_level == LVL_DATA |-> red_level == LVL_DATA && blue_level == LVL_DATA)
    else $error("override on one channel only");
  a_sync_pos: assert property (
    out_valid && green_level == LVL_SYNC_POS |-> green_luma_out == CODE_SYNC_POS)
    else $error("positive sync code wrong");
  a_sync_neg: assert property (
    out_valid && green_level == LVL_SYNC_NEG |-> green_luma_out == CODE_SYNC_NEG)
    else $error("negative sync code wrong");
  a_sync_pair: assert property (
    out_valid && green_level[1] |->
      red_level == blue_level && (red_level == green_level || red_level == LVL_BLANK))
    else $error("sync insertion mismatch");

  // ==========================================================
  // Mode latch
  a_all_latch: assert property (
    $fell(sync_n) ##1 $stable(sync_n) |=> sync_on_all_bit == $past(mode_sel_latched_pin))
    else $error("sync-on-all bit not latched");
  a_col_latch: assert property (
    $rose(sync_n) ##1 $stable(sync_n) |=> colour_format_bit == $past(mode_sel_latched_pin))
    else $error("colour bit not latched");
  a_col_hold: assert property (
    $changed(colour_format_bit) |-> $past(sync_n, 2) != $past(sync_n, 3))
    else $error("colour bit moved without sync edge");

  c_sync_all: cover property (out_valid && red_level[1]);
  c_blank: cover property (out_valid && green_level == LVL_BLANK);
  c_stall: cover property (out_valid && !out_ready);
endmodule : video_dac_chk

bind video_dac_input_mode_latch video_dac_chk i_chk (
  .clk, .sys_rst, .sync_n, .mode_sel_latched_pin, .out_valid, .out_ready,
  .red_pr_out, .green_luma_out, .blue_pb_out, .red_level, .green_level,
  .blue_level, .colour_format_bit, .sync_on_all_bit
);

`default_nettype wire

// file: verification/conv_sink.sv
/*
  Converter-side partner: takes words with random back-pressure.
  Assumes the bench raises stall to hold it off completely.
*/
`default_nettype none

module conv_sink (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Handshake
  input  wire logic stall,
  output var logic  out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      out_ready <= 1'b0;
    else
      out_ready <= !stall && ($urandom % 4 != 0);
  end
endmodule : conv_sink

`default_nettype wire

// file: verification/video_dac_input_mode_latch_tb.sv
/*
  Self-checking bench for the video DAC front end.
  Assumes the DUT, its FIFO, the checker bind and conv_sink.
*/
`default_nettype none

module video_dac_input_mode_latch_tb
  import dac_front_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, sys_rst, pixel_valid, in_ready, blank_n, sync_n, sync_tri;
  logic              mode_sel_direct, mode_sel_latched_pin, out_valid, out_ready, stall;
  logic              colour_format_bit, sync_on_all_bit, reg_wr, reg_rd, clk_en;
  logic [PIX_W-1:0]  red_pr_in, green_luma_in, blue_pb_in;
  logic [PIX_W-1:0]  red_pr_out, green_luma_out, blue_pb_out;
  logic [LVL_W-1:0]  red_level, green_level, blue_level;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic              m_prev, m_pend, m_dir, e_col, e_all, k_col, k_all, force_b;
  logic [35:0]       q[$];
  int                n_mismatch, n_tests, cyc;

  video_dac_input_mode_latch i_dut (
    .clk, .sys_rst, .clk_en, .pixel_valid, .red_pr_in, .green_luma_in,
    .blue_pb_in, .in_ready, .blank_n, .sync_n, .sync_tri, .mode_sel_direct,
    .mode_sel_latched_pin, .out_valid, .out_ready, .red_pr_out, .green_luma_out,
    .blue_pb_out, .red_level, .green_level, .blue_level, .colour_format_bit,
    .sync_on_all_bit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );

  conv_sink i_sink (.clk, .sys_rst, .stall, .out_ready);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Expected word: codes then levels
  function automatic logic [35:0] expw(input logic [29:0] px,
                                       input logic bn, sn, tr, fb, d, c, a);
    logic [9:0] bc;
    logic [9:0] sc;
    logic [1:0] sl;
    bc = ({d, c} != 2'h0) ? CODE_MID : CODE_ZERO;
    sc = tr ? CODE_SYNC_POS : CODE_SYNC_NEG;
    sl = tr ? 2'h3 : 2'h2;
    if (!sn) return a ? {sc, sc, sc, sl, sl, sl} : {bc, sc, bc, 2'h1, sl, 2'h1};
    if (!bn || fb) return {bc, CODE_ZERO, bc, 6'h15};
    return {px, 6'h00};
  endfunction : expw

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic reg_wr_t(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_rd_t(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check({4'h0, reg_rdata}, {4'h0, e});
  endtask : reg_rd_t

  // ==========================================================
  // Driver-side notes and mode latch model
  always @(posedge clk) begin
    if (sys_rst) begin
      {m_prev, m_pend, e_col, e_all, k_col, k_all} = 6'h20;
    end else if (clk_en) begin
      // Latch first: the word is built with the bits that stand after this edge
      if (m_pend && m_dir)
        {e_col, k_col} = {mode_sel_latched_pin, 1'b1};
      if (m_pend && !m_dir)
        {e_all, k_all} = {mode_sel_latched_pin, 1'b1};
      if (pixel_valid && in_ready)
        q.push_back(expw({red_pr_in, green_luma_in, blue_pb_in}, blank_n, sync_n,
                         sync_tri, force_b, mode_sel_direct, e_col, e_all));
      m_pend = (sync_n != m_prev);
      m_dir = sync_n;
      m_prev = sync_n;
    end
  end

  // ==========================================================
  // Output watcher and timeout
  always @(posedge clk) begin
    cyc++;
    if (!sys_rst && clk_en && out_valid && out_ready)
      check({red_pr_out, green_luma_out, blue_pb_out, red_level, green_level, blue_level},
            q.size() ? q.pop_front() : 36'hx);
    if (cyc > 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  always @(negedge clk) begin
    if (!sys_rst)
      check({34'h0, colour_format_bit, sync_on_all_bit}, {34'h0, e_col, e_all});
  end

  // ==========================================================
  // Main sequence
  initial begin
    {pixel_valid, reg_wr, reg_rd, stall, sync_tri, force_b} = '0;
    {mode_sel_direct, mode_sel_latched_pin, reg_addr, reg_wdata} = '0;
    {red_pr_in, green_luma_in, blue_pb_in} = '0;
    {blank_n, sync_n, sys_rst, clk_en} = 4'hf;
    void'($urandom(30));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    sync_n <= 1'b1;
    reg_rd_t(4'h8, 32'h0);
    for (int ph = 0; ph < 4; ph++) begin
      mode_sel_direct <= ph[0];
      reg_wr_t(REG_CTRL, {31'h0, ph[1]});
      force_b = ph[1];
      reg_rd_t(REG_CTRL, {31'h0, ph[1]});
      repeat (200) begin
        @(posedge clk);
        pixel_valid <= 1'($urandom);
        {red_pr_in, green_luma_in, blue_pb_in} <= 30'($urandom);
        blank_n <= ($urandom % 4) != 0;
        sync_tri <= 1'($urandom);
        mode_sel_latched_pin <= 1'($urandom);
        stall <= (cyc % 64) < 12;
        if (cyc % 5 == 0)
          sync_n <= 1'($urandom);
      end
      stall <= 1'b1;
      pixel_valid <= 1'b1;
      repeat (12) @(posedge clk);
      @(negedge clk);
      check({35'h0, in_ready}, 36'h0);
      @(posedge clk);
      {stall, pixel_valid} <= 2'h0;
      repeat (30) @(posedge clk);
      reg_rd_t(REG_STATUS, {25'h0, mode_sel_direct, k_all, k_col, e_all, e_col,
                            mode_sel_direct, e_col});
      // Frozen clock enable: this write must not land
      clk_en <= 1'b0;
      reg_wr_t(REG_CTRL, {31'h0, !ph[1]});
      clk_en <= 1'b1;
      reg_rd_t(REG_CTRL, {31'h0, ph[1]});
    end
    check(36'(q.size()), 36'h0);
    print_verdict();
  end
endmodule : video_dac_input_mode_latch_tb

`default_nettype wire
